// file: inc/spm_cfg.svh
// Constants for the switch power and link state controller: encodings,
// field defaults, port capability masks and timing counts.
// Assumes a 200 MHz core clock and three ports: A (root-facing), B, C.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// Power-state field encodings written by software
`define SPM_FIELD_D0        2'h0
`define SPM_FIELD_D3HOT     2'h3

// Port capability masks, bit 0 is port A
`define SPM_ASPM_L0S_CAP      3'h7
`define SPM_ASPM_L1_CAP       3'h3
`define SPM_L1_REQ_PORTS      3'h1

// Timing: core clock, entry timer tick, wake message service time-out
`define SPM_CLK_PERIOD_NS     5
`define SPM_TICK_NS           1000
`define SPM_TICK_CYC          ((`SPM_TICK_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS)
`define SPM_PME_TIMEOUT_MS    100
`define SPM_PME_TIMEOUT_CYC   ((`SPM_PME_TIMEOUT_MS * 1000000) / `SPM_CLK_PERIOD_NS)

// Reset values
`define SPM_TIMER_RST         8'h00
`define SPM_PME_CNT_RST       25'h0000000

`endif

// file: inc/spm_pkg.sv
// Types shared by the switch power and link state controller.
// Assumes spm_cfg.svh provides the numeric constants.
package spm_pkg;

	// Bridge power states, Gray along D0U -> D0A -> D3hot -> D3cold
	typedef enum logic [1:0]
	{
		SPM_D0_UNINIT = 2'h0,
		SPM_D0_ACTIVE = 2'h1,
		SPM_D3_HOT    = 2'h3,
		SPM_D3_COLD   = 2'h2
	} spm_dstate_e;

	// Link states, Gray along L0 -> L0s -> L1 request -> L1 -> L2/L3 -> L3
	typedef enum logic [2:0]
	{
		SPM_L0      = 3'h0,
		SPM_L0S     = 3'h1,
		SPM_L1_REQ  = 3'h3,
		SPM_L1      = 3'h2,
		SPM_L23_RDY = 3'h6,
		SPM_L3      = 3'h7
	} spm_lstate_e;

endpackage

// file: rtl/spm_aspm_link.sv
// Link state machine of one port: L0s/L1 entry timers, L1 handshake, exits.
// Assumes partner and data-link inputs are core-clock logic, not pins.
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_aspm_link
(
	input  wire logic                clk_in,          // Core clock
	input  wire logic                srst_in,         // Sync reset, high
	input  wire logic                l0s_en_in,       // L0s enabled and supported
	input  wire logic                l1_en_in,        // L1 enabled and supported
	input  wire logic                l1_req_allow_in, // Port may originate L1 requests
	input  wire logic                idle_in,         // Entry conditions hold
	input  wire logic                tx_pending_in,   // Packet waits to be sent
	input  wire logic                partner_exit_in, // Partner starts an exit
	input  wire logic                l1_ack_in,       // Partner accepts L1
	input  wire logic                l1_nak_in,       // Partner refuses L1
	input  wire logic                d3hot_in,        // Bridge in D3hot
	input  wire logic                l23_enter_in,    // Turn-off acknowledged
	input  wire logic                power_off_in,    // Power removed
	input  wire logic                tick_in,         // Entry timer tick
	input  wire logic [7:0]          l0s_time_in,     // L0s entry time in ticks
	input  wire logic [7:0]          l1_time_in,      // L1 entry time in ticks
	output spm_pkg::spm_lstate_e     state_out,       // Link state, registered
	output logic                     l1_req_out,      // L1 request level, registered
	output logic                     tx_block_out     // No TLP/DLLP allowed, registered
);
	import spm_pkg::*;

	spm_lstate_e state_reg;      // Link state
	spm_lstate_e state_next;
	logic [7:0]  l0s_cnt_reg;    // Ticks with L0s conditions unbroken
	logic [7:0]  l0s_cnt_next;
	logic [7:0]  l1_cnt_reg;     // Ticks with L1 conditions unbroken
	logic [7:0]  l1_cnt_next;
	logic        l1_req_reg;
	logic        l1_req_next;
	logic        block_reg;
	logic        block_next;
	logic        wake;           // Exit cause
	logic        l0s_met;
	logic        l1_met;

	// Next state; hardware alone steps the link once enabled
	always_comb
	begin
		wake         = tx_pending_in || partner_exit_in;
		l0s_cnt_next = (idle_in && state_reg == SPM_L0) ? l0s_cnt_reg : `SPM_TIMER_RST;
		l1_cnt_next  = (idle_in && (state_reg == SPM_L0 || state_reg == SPM_L0S)) ?
			l1_cnt_reg : `SPM_TIMER_RST;
		if (tick_in && l0s_cnt_next != 8'hff && l0s_cnt_next != `SPM_TIMER_RST)
			l0s_cnt_next = l0s_cnt_next + 8'h01;
		else if (tick_in && idle_in && state_reg == SPM_L0 && l0s_cnt_next == `SPM_TIMER_RST)
			l0s_cnt_next = 8'h01;
		if (tick_in && l1_cnt_next != 8'hff && l1_cnt_next != `SPM_TIMER_RST)
			l1_cnt_next = l1_cnt_next + 8'h01;
		else if (tick_in && idle_in && l1_cnt_next == `SPM_TIMER_RST &&
			(state_reg == SPM_L0 || state_reg == SPM_L0S))
			l1_cnt_next = 8'h01;
		l0s_met = idle_in && (l0s_cnt_reg >= l0s_time_in);
		l1_met  = idle_in && l1_en_in && l1_req_allow_in && (l1_cnt_reg >= l1_time_in);
		state_next = state_reg;
		case (state_reg)
			SPM_L0:
				if (l23_enter_in)
					state_next = SPM_L23_RDY;
				else if (d3hot_in && idle_in && !tx_pending_in)
					state_next = SPM_L1;
				else if (l1_met)
					state_next = SPM_L1_REQ;
				else if (l0s_en_in && l0s_met)
					state_next = SPM_L0S;
			SPM_L0S:
				if (wake)
					state_next = SPM_L0;
				else if (d3hot_in && idle_in)
					state_next = SPM_L1;
				else if (l1_met)
					state_next = SPM_L1_REQ;
			SPM_L1_REQ:
				if (l1_ack_in)
					state_next = SPM_L1;
				else if (l1_nak_in)
					state_next = SPM_L0;
			SPM_L1:
				if (wake)
					state_next = SPM_L0;
			SPM_L23_RDY:
				// Left only by reset or power loss
				state_next = SPM_L23_RDY;
			SPM_L3:
				state_next = SPM_L3;
			default:
				state_next = SPM_L0;
		endcase
		if (power_off_in)
			state_next = SPM_L3;
		l1_req_next = (state_next == SPM_L1_REQ);
		block_next  = (state_next == SPM_L23_RDY) || (state_next == SPM_L3);
	end

	// Registers only
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			state_reg   <= SPM_L0;
			l0s_cnt_reg <= `SPM_TIMER_RST;
			l1_cnt_reg  <= `SPM_TIMER_RST;
			l1_req_reg  <= 1'b0;
			block_reg   <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			l0s_cnt_reg <= l0s_cnt_next;
			l1_cnt_reg  <= l1_cnt_next;
			l1_req_reg  <= l1_req_next;
			block_reg   <= block_next;
		end
	end

	assign state_out    = state_reg;
	assign l1_req_out   = l1_req_reg;
	assign tx_block_out = block_reg;

endmodule

// file: rtl/spm_bridge_pm.sv
// Power state machine of one bridge.
// Assumes configuration and power-state writes arrive as core-clock pulses.
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_bridge_pm
(
	input  wire logic                clk_in,        // Core clock
	input  wire logic                srst_in,       // Fundamental reset, sync high
	input  wire logic                cfg_done_in,   // Bridge configured pulse
	input  wire logic                pm_wr_in,      // Power-state field write pulse
	input  wire logic [1:0]          pm_state_in,   // Value written to the field
	input  wire logic                power_off_in,  // Power removed
	output spm_pkg::spm_dstate_e     dstate_out     // Current state, registered
);
	import spm_pkg::*;

	spm_dstate_e dstate_reg;   // State register
	spm_dstate_e dstate_next;  // Next state

	// Next state; a D3hot to D0U move only changes this state, nothing else
	always_comb
	begin
		dstate_next = dstate_reg;
		case (dstate_reg)
			SPM_D0_UNINIT:
				if (cfg_done_in)
					dstate_next = SPM_D0_ACTIVE;
			SPM_D0_ACTIVE:
				if (pm_wr_in && pm_state_in == `SPM_FIELD_D3HOT)
					dstate_next = SPM_D3_HOT;
			SPM_D3_HOT:
				if (pm_wr_in && pm_state_in == `SPM_FIELD_D0)
					dstate_next = SPM_D0_UNINIT;
			SPM_D3_COLD:
				// Only a fundamental reset leaves D3cold
				dstate_next = SPM_D3_COLD;
			default:
				dstate_next = SPM_D0_UNINIT;
		endcase
		if (power_off_in && dstate_reg == SPM_D3_HOT)
			dstate_next = SPM_D3_COLD;
	end

	// Reset forces D0U from any state
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			dstate_reg <= SPM_D0_UNINIT;
		else
			dstate_reg <= dstate_next;
	end

	assign dstate_out = dstate_reg;

endmodule

// file: rtl/spm_top.sv
// Top of the switch power and link state controller: three bridge power
// state machines, three link state machines, the device-wide low-power
// state of the root-facing port, entry timer tick and wake message retries.
// Assumes all inputs are core-clock logic (configuration space, data link
// layer); software-visible fields arrive as plain levels and write pulses.
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_top
#(
	parameter int unsigned PME_TIMEOUT_CYC = `SPM_PME_TIMEOUT_CYC  // Wake service time-out
)
(
	input  wire logic                clk_in,                 // Core clock, 200 MHz
	input  wire logic                srst_in,                // Fundamental reset, sync high
	input  wire logic [2:0]          cfg_done_in,            // Bridge configured pulse, per port
	input  wire logic [2:0]          pm_wr_in,               // Control/status register write, per port
	input  wire logic [1:0]          power_state_field_in,   // Power-state field write data
	input  wire logic                power_off_in,           // Power removed from device
	input  wire logic [2:0]          aspm_l0s_en_in,         // Link control L0s enable, per port
	input  wire logic [2:0]          aspm_l1_en_in,          // Link control L1 enable, per port
	input  wire logic [7:0]          l0s_entry_timer_in,     // L0s entry time, microseconds
	input  wire logic [7:0]          l1_entry_timer_in,      // L1 entry time, microseconds
	input  wire logic [2:0]          link_idle_in,           // Link entry conditions hold
	input  wire logic [2:0]          tx_pending_in,          // Packet pending, per port
	input  wire logic [2:0]          partner_exit_in,        // Partner exits low power
	input  wire logic [2:0]          l1_ack_in,              // Partner accepts L1 request
	input  wire logic [2:0]          l1_nak_in,              // Partner refuses L1 request
	input  wire logic                pme_to_ack_in,          // Turn-off acknowledgements received
	input  wire logic [1:0]          pme_event_in,           // Hot-plug wake event, ports B, C
	input  wire logic [1:0]          pme_serviced_in,        // Software serviced wake, ports B, C
	output spm_pkg::spm_dstate_e     dstate_a_out,           // Port A bridge state
	output spm_pkg::spm_dstate_e     dstate_b_out,           // Port B bridge state
	output spm_pkg::spm_dstate_e     dstate_c_out,           // Port C bridge state
	output spm_pkg::spm_lstate_e     link_state_a_out,       // Port A link state
	output spm_pkg::spm_lstate_e     link_state_b_out,       // Port B link state
	output spm_pkg::spm_lstate_e     link_state_c_out,       // Port C link state
	output logic [2:0]               l1_req_out,             // L1 entry request level
	output logic [2:0]               link_tx_block_out,      // TLP/DLLP traffic blocked
	output logic [1:0]               pme_send_out,           // Send wake message pulse, B, C
	output logic [1:0]               pme_pending_out,        // Wake awaiting service, B, C
	output logic                     switch_low_power_out    // Whole switch in low power
);
	import spm_pkg::*;

	// Tick counter reload and wake time-out reload, sized to their counters
	localparam logic [7:0]  TICK_LAST = 8'(`SPM_TICK_CYC - 1);
	localparam logic [24:0] PME_LAST  = 25'(PME_TIMEOUT_CYC - 1);
	// Masks as named constants; a literal cannot be bit-selected
	localparam logic [2:0]  L0S_CAP   = `SPM_ASPM_L0S_CAP;
	localparam logic [2:0]  L1_CAP    = `SPM_ASPM_L1_CAP;
	localparam logic [2:0]  L1_ORIG   = `SPM_L1_REQ_PORTS;

	// True when a bridge is in D3hot; used by links and device state
	function automatic logic is_d3hot(input spm_dstate_e st);
		is_d3hot = (st == SPM_D3_HOT);
	endfunction

	// True when a bridge may emit wake messages
	function automatic logic pme_allowed(input spm_dstate_e st);
		pme_allowed = (st == SPM_D0_ACTIVE) || (st == SPM_D3_HOT);
	endfunction

	spm_dstate_e dstate [3];          // Bridge states, index 0 is port A
	spm_lstate_e lstate [3];          // Link states
	logic [2:0]  d3_link;             // Link may be directed to L1
	logic [2:0]  l1_req_w;            // Request levels from links
	logic [2:0]  block_w;             // Traffic block from links

	logic [7:0]  tick_cnt_reg;        // Microsecond prescaler
	logic [7:0]  tick_cnt_next;
	logic        tick_reg;            // One-cycle tick
	logic        tick_next;

	logic        ack_seen_reg;        // Acks seen while root port low
	logic        ack_seen_next;
	logic        switch_lp_reg;       // Whole-switch low power
	logic        switch_lp_next;

	logic [1:0]  pme_pend_reg;        // Wake messages awaiting service
	logic [1:0]  pme_pend_next;
	logic [1:0]  pme_send_reg;        // Send pulses
	logic [1:0]  pme_send_next;
	logic [24:0] pme_cnt_reg [2];     // Service time-out counters
	logic [24:0] pme_cnt_next [2];

	// Per-port power and link machines
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_port
			// Each bridge has its own state
			spm_bridge_pm u_bridge
			(
				.clk_in       (clk_in),
				.srst_in      (srst_in),
				.cfg_done_in  (cfg_done_in[gi]),
				.pm_wr_in     (pm_wr_in[gi]),
				.pm_state_in  (power_state_field_in),
				.power_off_in (power_off_in),
				.dstate_out   (dstate[gi])
			);

			// D3hot lets its link go to L1; the switch state covers all
			assign d3_link[gi] = is_d3hot(dstate[gi]) || switch_lp_reg;

			// Capability masks gate L0s, L1 and requests
			spm_aspm_link u_link
			(
				.clk_in          (clk_in),
				.srst_in         (srst_in),
				.l0s_en_in       (aspm_l0s_en_in[gi] && L0S_CAP[gi]),
				.l1_en_in        (aspm_l1_en_in[gi] && L1_CAP[gi]),
				.l1_req_allow_in (L1_ORIG[gi]),
				.idle_in         (link_idle_in[gi]),
				.tx_pending_in   (tx_pending_in[gi]),
				.partner_exit_in (partner_exit_in[gi]),
				.l1_ack_in       (l1_ack_in[gi]),
				.l1_nak_in       (l1_nak_in[gi]),
				.d3hot_in        (d3_link[gi]),
				.l23_enter_in    (switch_lp_reg),
				.power_off_in    (power_off_in),
				.tick_in         (tick_reg),
				.l0s_time_in     (l0s_entry_timer_in),
				.l1_time_in      (l1_entry_timer_in),
				.state_out       (lstate[gi]),
				.l1_req_out      (l1_req_w[gi]),
				.tx_block_out    (block_w[gi])
			);
		end
	endgenerate

	// Prescaler for the entry timers; one tick per microsecond
	always_comb
	begin
		tick_next     = 1'b0;
		tick_cnt_next = tick_cnt_reg - 8'h01;
		if (tick_cnt_reg == 8'h00)
		begin
			// Reload and fire
			tick_cnt_next = TICK_LAST;
			tick_next     = 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			tick_cnt_reg <= 8'h00;
			tick_reg     <= 1'b0;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg     <= tick_next;
		end
	end

	// Device-wide state follows the root-facing port
	always_comb
	begin
		ack_seen_next = ack_seen_reg;
		// Leaving D3hot forgets earlier acks
		if (!is_d3hot(dstate[0]))
			ack_seen_next = 1'b0;
		// An ack counts only while the root port is already in D3hot
		if (pme_to_ack_in && is_d3hot(dstate[0]))
			ack_seen_next = 1'b1;
		// Root port low and acks in: whole switch low
		switch_lp_next = is_d3hot(dstate[0]) && ack_seen_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			ack_seen_reg  <= 1'b0;
			switch_lp_reg <= 1'b0;
		end
		else
		begin
			ack_seen_reg  <= ack_seen_next;
			switch_lp_reg <= switch_lp_next;
		end
	end

	// Wake messages of ports B and C with re-send on service time-out.
	// A long time-out trades bus traffic for slower recovery of a lost message.
	always_comb
	begin
		pme_pend_next = pme_pend_reg;
		pme_send_next = 2'b00;
		for (int i = 0; i < 2; i++)
		begin
			pme_cnt_next[i] = pme_cnt_reg[i];
			if (pme_pend_reg[i])
			begin
				if (pme_cnt_reg[i] == `SPM_PME_CNT_RST)
				begin
					pme_cnt_next[i]  = PME_LAST;
					pme_send_next[i] = pme_allowed(dstate[i + 1]);
				end
				else
					pme_cnt_next[i] = pme_cnt_reg[i] - 25'h0000001;
			end
			// Serviced: stop retrying
			if (pme_serviced_in[i])
				pme_pend_next[i] = 1'b0;
			// New event, D0 active or D3hot only; set wins
			if (pme_event_in[i] && pme_allowed(dstate[i + 1]) && !pme_pend_reg[i])
			begin
				pme_pend_next[i] = 1'b1;
				pme_send_next[i] = 1'b1;
				pme_cnt_next[i]  = PME_LAST;
			end
			else if (pme_event_in[i] && pme_allowed(dstate[i + 1]) && pme_serviced_in[i])
				pme_pend_next[i] = 1'b1;
			if (dstate[i + 1] == SPM_D3_COLD)
			begin
				pme_pend_next[i] = 1'b0;
				pme_send_next[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			pme_pend_reg <= 2'b00;
			pme_send_reg <= 2'b00;
			pme_cnt_reg[0] <= `SPM_PME_CNT_RST;
			pme_cnt_reg[1] <= `SPM_PME_CNT_RST;
		end
		else
		begin
			pme_pend_reg <= pme_pend_next;
			pme_send_reg <= pme_send_next;
			pme_cnt_reg[0] <= pme_cnt_next[0];
			pme_cnt_reg[1] <= pme_cnt_next[1];
		end
	end

	// Outputs, each straight from a register here or in a submodule
	assign dstate_a_out         = dstate[0];
	assign dstate_b_out         = dstate[1];
	assign dstate_c_out         = dstate[2];
	assign link_state_a_out     = lstate[0];
	assign link_state_b_out     = lstate[1];
	assign link_state_c_out     = lstate[2];
	assign l1_req_out           = l1_req_w;
	assign link_tx_block_out    = block_w;
	assign pme_send_out         = pme_send_reg;
	assign pme_pending_out      = pme_pend_reg;
	assign switch_low_power_out = switch_lp_reg;

endmodule

// file: test/spm_link_partner.sv
// Link partner model: accepts or refuses L1 entry requests per port.
// Assumes requests are registered levels held until answered.
`timescale 1ns/1ps
module spm_link_partner
(
	input  wire logic [2:0] l1_req_in,  // Request levels
	input  wire logic       clk_in,     // Core clock
	input  wire logic       srst_in,    // Sync reset
	input  wire logic [7:0] delay_in,   // Answer delay, cycles
	input  wire logic       refuse_in,  // Refuse, not accept
	output logic      [2:0] l1_ack_out, // Accept pulse
	output logic      [2:0] l1_nak_out  // Refuse pulse
);
	logic [7:0] wait_reg [3]; // Cycles each request has waited

	// Answer each request
	// One answer per request; a slow delay stalls the handshake
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < 3; i++)
		begin
			l1_ack_out[i] <= 1'b0;
			l1_nak_out[i] <= 1'b0;
			if (srst_in || !l1_req_in[i])
				wait_reg[i] <= 8'h00;
			else if (wait_reg[i] <= delay_in)
			begin
				l1_ack_out[i] <= (wait_reg[i] == delay_in) && !refuse_in;
				l1_nak_out[i] <= (wait_reg[i] == delay_in) && refuse_in;
				wait_reg[i] <= wait_reg[i] + 8'h01;
			end
		end
	end
endmodule

// file: test/spm_top_assertions.sv
// Port checker of spm_top: bridge, link and device-wide state relations.
// Assumes a bind onto spm_top and one core clock domain.
`timescale 1ns/1ps
module spm_top_assertions
	import spm_pkg::*;
#(
	parameter int unsigned PME_TIMEOUT_CYC = 20 // Wake time-out
)
(
	input wire logic        clk_in,               // Core clock
	input wire logic        srst_in,              // Sync reset
	input wire logic [2:0]  pm_wr_in,             // Field writes
	input wire logic [1:0]  power_state_field_in, // Field data
	input wire logic [2:0]  l1_ack_in,            // Partner accepts
	input wire logic [2:0]  tx_pending_in,        // Packet pending
	input wire logic        power_off_in,         // Power removed
	input wire logic        pme_to_ack_in,        // Turn-off acks
	input spm_dstate_e      dstate_a_out,         // Port A bridge
	input spm_dstate_e      dstate_c_out,         // Port C bridge
	input spm_lstate_e      link_state_a_out,     // Port A link
	input wire logic [2:0]  l1_req_out,           // L1 requests
	input wire logic [2:0]  link_tx_block_out,    // Traffic blocked
	input wire logic        switch_low_power_out  // Device low
);
	logic [2:0] wr_q;  // Writes seen last edge
	logic [1:0] fld_q; // Data seen last edge
	logic       ack_q; // Port A accept seen last edge

	// Delayed copies, so a state change can be tied to its cause
	always_ff @(posedge clk_in)
	begin
		wr_q  <= pm_wr_in;
		fld_q <= power_state_field_in;
		ack_q <= l1_ack_in[0];
	end

	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	property p_req_a_only;
		l1_req_out[2:1] == 2'h0;
	endproperty
	a_req_a_only: assert property (p_req_a_only)
		else $error("downstream port raised an L1 request");
	property p_req_level;
		l1_req_out[0] == (link_state_a_out == SPM_L1_REQ);
	endproperty
	a_req_level: assert property (p_req_level)
		else $error("L1 request level disagrees with link state");
	property p_l1_after_ack;
		(link_state_a_out == SPM_L1 && $past(link_state_a_out) == SPM_L1_REQ) |-> ack_q;
	endproperty
	a_l1_after_ack: assert property (p_l1_after_ack)
		else $error("L1 entered without an accept");
	property p_blocked;
		link_tx_block_out[0] == (link_state_a_out inside {SPM_L23_RDY, SPM_L3});
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("traffic block disagrees with link state");
	property p_to_d3hot;
		(dstate_c_out == SPM_D3_HOT && $past(dstate_c_out) == SPM_D0_ACTIVE) |-> wr_q[2] && fld_q == 2'h3;
	endproperty
	a_to_d3hot: assert property (p_to_d3hot)
		else $error("D3hot entered without a D3hot write");
	property p_to_d0u;
		(dstate_c_out == SPM_D0_UNINIT && $past(dstate_c_out) == SPM_D3_HOT && !$past(srst_in))
			|-> wr_q[2] && fld_q == 2'h0;
	endproperty
	a_to_d0u: assert property (p_to_d0u)
		else $error("D3hot left without a D0 write");
	property p_l0s_wake;
		(link_state_a_out == SPM_L0S && tx_pending_in[0] && !power_off_in) |=> link_state_a_out == SPM_L0;
	endproperty
	a_l0s_wake: assert property (p_l0s_wake)
		else $error("pending packet did not wake the link");
	property p_low_power;
		(pme_to_ack_in && dstate_a_out == SPM_D3_HOT) |=> switch_low_power_out;
	endproperty
	a_low_power: assert property (p_low_power)
		else $error("switch did not go low after acks");

	c_l1: cover property (link_state_a_out == SPM_L1);
	c_d3: cover property (dstate_c_out == SPM_D3_HOT);
	c_low: cover property (switch_low_power_out);
endmodule

// file: test/tb_spm_top.sv
// Testbench of spm_top: random entry times and partner delays.
// Assumes the partner model and the checker are compiled first.
`timescale 1ns/1ps
module tb_spm_top;
	import spm_pkg::*;
	logic        clk_in = 1'b0;  // Core clock
	logic        srst_in = 1'b1; // Sync reset
	logic [2:0]  cfg_done_in, pm_wr_in, aspm_l0s_en_in, aspm_l1_en_in, link_idle_in; // Config
	logic [2:0]  tx_pending_in, partner_exit_in, l1_ack_in, l1_nak_in; // Link side
	logic [1:0]  power_state_field_in, pme_event_in, pme_serviced_in; // Field, wake
	logic [7:0]  l0s_entry_timer_in, l1_entry_timer_in, p_delay; // Times
	logic        power_off_in, pme_to_ack_in, p_refuse; // Power, partner
	spm_dstate_e dstate_a_out, dstate_b_out, dstate_c_out; // Bridges
	spm_lstate_e link_state_a_out, link_state_b_out, link_state_c_out; // Links
	logic [2:0]  l1_req_out, link_tx_block_out; // Link flags
	logic [1:0]  pme_send_out, pme_pending_out; // Wake
	logic        switch_low_power_out; // Device low
	int          bad_count, check_count, cycles, n, t, seed; // Counters

	always #2.5 clk_in = ~clk_in;

	// Short wake time-out keeps resend checks brief
	spm_top #(.PME_TIMEOUT_CYC(20)) DUT (.clk_in, .srst_in, .cfg_done_in, .pm_wr_in, .power_state_field_in,
		.power_off_in, .aspm_l0s_en_in, .aspm_l1_en_in, .l0s_entry_timer_in, .l1_entry_timer_in, .link_idle_in,
		.tx_pending_in, .partner_exit_in, .l1_ack_in, .l1_nak_in, .pme_to_ack_in, .pme_event_in,
		.pme_serviced_in, .dstate_a_out, .dstate_b_out, .dstate_c_out, .link_state_a_out, .link_state_b_out,
		.link_state_c_out, .l1_req_out, .link_tx_block_out, .pme_send_out, .pme_pending_out, .switch_low_power_out);
	spm_link_partner u_partner (.clk_in, .srst_in, .l1_req_in(l1_req_out), .delay_in(p_delay),
		.refuse_in(p_refuse), .l1_ack_out(l1_ack_in), .l1_nak_out(l1_nak_in));

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask

	// Bounded wait for a port A link state; n gets the cycles taken
	task automatic wait_a(input spm_lstate_e s);
		n = 0;
		while (link_state_a_out !== s && n < 3000)
		begin
			@(posedge clk_in);
			#1 n++;
		end
	endtask

	// Entry after t ticks of 200 cycles, tick phase unknown
	function automatic logic in_win(input int c, input int k);
		return c >= k * 200 - 200 && c <= k * 200 + 8;
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			finish_test();
		end
	end

	initial
	begin
		seed = 32'hc49a;
		{cfg_done_in, pm_wr_in, aspm_l0s_en_in, aspm_l1_en_in, link_idle_in, tx_pending_in} = '0;
		{partner_exit_in, power_state_field_in, pme_event_in, pme_serviced_in, power_off_in} = '0;
		{l0s_entry_timer_in, l1_entry_timer_in, p_delay, pme_to_ack_in, p_refuse} = '0;
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		pme_event_in <= 2'h3;
		#1 chk("reset state", SPM_D0_UNINIT, dstate_b_out);
		@(posedge clk_in);
		{pme_event_in, cfg_done_in} <= 5'h07;
		@(posedge clk_in);
		cfg_done_in <= 3'h0;
		t = 1 + ($random(seed) & 3);
		l1_entry_timer_in <= t[7:0];
		p_delay <= 8'($random(seed) & 7);
		{aspm_l1_en_in, link_idle_in} <= 6'h3f;
		#1 chk("wake in D0U", 2'h0, pme_pending_out);
		chk("configured", SPM_D0_ACTIVE, dstate_c_out);
		wait_a(SPM_L1_REQ);
		chk("l1 entry time", 1'b1, in_win(n, t));
		chk("l1 request", 3'h1, l1_req_out);
		chk("port b link", SPM_L0, link_state_b_out);
		wait_a(SPM_L1);
		chk("l1 entered", SPM_L1, link_state_a_out);
		@(posedge clk_in);
		{partner_exit_in, p_refuse} <= 4'h3;
		@(posedge clk_in);
		partner_exit_in <= 3'h0;
		#1 chk("partner exit", SPM_L0, link_state_a_out);
		wait_a(SPM_L1_REQ);
		wait_a(SPM_L0);
		chk("refused", 1'b1, n <= p_delay + 3);
		@(posedge clk_in);
		{aspm_l1_en_in, p_refuse} <= '0;
		t = 1 + ($random(seed) & 3);
		l0s_entry_timer_in <= t[7:0];
		aspm_l0s_en_in <= 3'h7;
		wait_a(SPM_L0S);
		chk("l0s entry time", 1'b1, in_win(n + 1000, t + 5));
		chk("port c l0s", SPM_L0S, link_state_c_out);
		@(posedge clk_in);
		{tx_pending_in, link_idle_in} <= 6'h0e;
		l0s_entry_timer_in <= 8'h02;
		@(posedge clk_in);
		tx_pending_in <= 3'h0;
		#1 chk("pending exit", SPM_L0, link_state_a_out);
		// Idle broken every 151 cycles, shorter than two ticks
		repeat (8)
		begin
			@(posedge clk_in);
			link_idle_in <= 3'h7;
			repeat (150) @(posedge clk_in);
			link_idle_in <= 3'h6;
		end
		#1 chk("broken idle", SPM_L0, link_state_a_out);
		@(posedge clk_in);
		aspm_l0s_en_in <= 3'h0;
		{pm_wr_in, power_state_field_in} <= 5'h09;
		@(posedge clk_in);
		power_state_field_in <= 2'h3;
		#1 chk("bad encoding", SPM_D0_ACTIVE, dstate_b_out);
		@(posedge clk_in);
		pm_wr_in <= 3'h0;
		#1 chk("b in D3hot", SPM_D3_HOT, dstate_b_out);
		chk("a unaffected", SPM_D0_ACTIVE, dstate_a_out);
		@(posedge clk_in);
		#1 chk("d3hot link", SPM_L1, link_state_b_out);
		n = 0;
		for (int i = 0; i < 72; i++)
		begin
			@(posedge clk_in);
			pme_event_in <= (i == 0) ? 2'h1 : 2'h0;
			#1 n += pme_send_out[0];
		end
		chk("wake sends", 8'h04, n[7:0]);
		chk("wake pending", 2'h1, pme_pending_out);
		@(posedge clk_in);
		pme_serviced_in <= 2'h1;
		{pm_wr_in, power_state_field_in} <= 5'h13;
		@(posedge clk_in);
		pme_serviced_in <= 2'h0;
		power_state_field_in <= 2'h0;
		#1 chk("serviced", 2'h0, pme_pending_out);
		@(posedge clk_in);
		{link_idle_in, pme_to_ack_in} <= 4'h1;
		{pm_wr_in, power_state_field_in} <= 5'h07;
		#1 chk("c back to D0U", SPM_D0_UNINIT, dstate_c_out);
		@(posedge clk_in);
		{pme_to_ack_in, pm_wr_in} <= '0;
		#1 chk("early ack", 1'b0, switch_low_power_out);
		@(posedge clk_in);
		pme_to_ack_in <= 1'b1;
		@(posedge clk_in);
		pme_to_ack_in <= 1'b0;
		#1 chk("switch low", 1'b1, switch_low_power_out);
		@(posedge clk_in);
		power_off_in <= 1'b1;
		#1 chk("blocked", 1'b1, link_tx_block_out[0]);
		@(posedge clk_in);
		pme_event_in <= 2'h1;
		#1 chk("b cold", SPM_D3_COLD, dstate_b_out);
		chk("link off", SPM_L3, link_state_a_out);
		repeat (3) @(posedge clk_in);
		#1 chk("cold wake", 2'h0, pme_pending_out);
		finish_test();
	end
endmodule

bind spm_top spm_top_assertions #(.PME_TIMEOUT_CYC(PME_TIMEOUT_CYC)) u_chk (.clk_in, .srst_in, .pm_wr_in,
	.power_state_field_in, .l1_ack_in, .tx_pending_in, .power_off_in, .pme_to_ack_in, .dstate_a_out,
	.dstate_c_out, .link_state_a_out, .l1_req_out, .link_tx_block_out, .switch_low_power_out);
